// ==== rtl/sru_regs.svh ====
// Decode fields and clock costs of the shift and rotate unit
// Behaviour
// RL1: Opcode 110100vw with middle field 101 is the logical right shift.
// RL2: Middle field 111 is the arithmetic right shift, filling with sign bit.
// RL3: Middle field 000 is rotate left, top bit wraps into bit zero.
// RL4: Middle field 001 is rotate right, bit zero wraps into the top bit.
// RL5: Middle field 011 rotates right through carry, carry in at the top.
// RL6: Single-bit form on a register operand completes in 2 clocks.
// RL7: Single-bit form on a memory operand takes 15 clocks plus address time.
// RL8: Variable form on a register takes 8 clocks plus 4 per bit.
// RL9: Variable form on memory takes 20 plus address time plus 4 per bit.
// RL10: Count-source bit clear means count one; set means low count byte.
// RL11: Width bit clear means 8-bit operand; set means 16-bit operand.
`ifndef SRU_REGS_SVH
`define SRU_REGS_SVH

// Opcode byte layout
`define SRU_OPC_GROUP 6'h34
`define SRU_V_BIT 1
`define SRU_W_BIT 0
`define SRU_MOD_REG 2'h3

// Middle field codes of the mode byte
`define SRU_SUB_ROTATE_LEFT 3'h0
`define SRU_SUB_ROTATE_RIGHT 3'h1
`define SRU_SUB_ROTATE_CARRY_RIGHT 3'h3
`define SRU_SUB_LOGICAL_RIGHT_SHIFT 3'h5
`define SRU_SUB_ARITHMETIC_RIGHT_SHIFT 3'h7

// Clock costs, in clocks
`define SRU_CLK_SINGLE_REG 8'h02
`define SRU_CLK_SINGLE_MEM 8'h0f
`define SRU_CLK_VAR_REG 8'h08
`define SRU_CLK_VAR_MEM 8'h14
`define SRU_CLK_PER_BIT 8'h04

`endif

// ==== rtl/sru_pkg.sv ====
// Types of the shift and rotate unit
package sru_pkg;

    typedef enum logic [2:0] {
        ROTATE_LEFT_OP,
        ROTATE_RIGHT_OP,
        ROTATE_CARRY_RIGHT_OP,
        LOGICAL_RIGHT_SHIFT,
        ARITHMETIC_RIGHT_SHIFT
    } sru_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BASE,
        ST_BITS
    } sru_state_t;

endpackage

// ==== rtl/sru_step_if.sv ====
// Link between the sequencer and the one-bit step datapath
`timescale 1ns/1ps
interface sru_step_if;
    logic [15:0] data;
    logic carry;
    logic wide;
    sru_pkg::sru_op_t op;
    logic [15:0] next_data;
    logic next_carry;

    modport core (
        output data, carry, wide, op,
        input next_data, next_carry
    );

    modport step (
        input data, carry, wide, op,
        output next_data, next_carry
    );
endinterface

// ==== rtl/sru_step.sv ====
// One-bit shift or rotate of an 8- or 16-bit operand
`timescale 1ns/1ps
module sru_step (
    // Step operands and result
    sru_step_if.step sif
);
    logic msb;
    logic fill;

    always_comb begin
        msb = sif.wide ? sif.data[15] : sif.data[7];
        fill = 1'b0;
        sif.next_data = sif.data;
        sif.next_carry = sif.carry;
        unique case (sif.op)
            sru_pkg::ROTATE_LEFT_OP: fill = msb; // RL3
            sru_pkg::ROTATE_RIGHT_OP: fill = sif.data[0]; // RL4
            sru_pkg::ROTATE_CARRY_RIGHT_OP: fill = sif.carry; // RL5
            sru_pkg::LOGICAL_RIGHT_SHIFT: fill = 1'b0; // RL1
            sru_pkg::ARITHMETIC_RIGHT_SHIFT: fill = msb; // RL2
            default: fill = 1'b0;
        endcase
        if (sif.op == sru_pkg::ROTATE_LEFT_OP) begin
            sif.next_carry = msb;
            if (sif.wide) begin
                sif.next_data = {sif.data[14:0], fill}; // RL11
            end else begin
                sif.next_data = {sif.data[15:8], sif.data[6:0], fill}; // RL11
            end
        end else if (sif.op != sru_pkg::ROTATE_LEFT_OP) begin
            sif.next_carry = sif.data[0];
            if (sif.wide) begin
                sif.next_data = {fill, sif.data[15:1]}; // RL11
            end else begin
                sif.next_data = {sif.data[15:8], fill, sif.data[7:1]}; // RL11
            end
        end
    end
endmodule

// ==== rtl/sru_top.sv ====
// Shift and rotate execution unit with instruction timing
`timescale 1ns/1ps
`include "sru_regs.svh"
module sru_top #(
    parameter int EA_W = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Instruction request
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_modrm,
    input wire logic [15:0] i_operand,
    input wire logic [15:0] i_count,
    input wire logic i_carry,
    input wire logic [EA_W-1:0] i_ea_time,
    // Completion
    output logic o_busy,
    output logic o_done,
    output logic o_illegal,
    output logic [15:0] o_result,
    output logic o_carry,
    output logic o_mem_operand
);
    sru_step_if sif ();

    sru_step u_step (
        .sif(sif.step)
    );

    // Decode of the presented instruction
    logic group_ok;
    logic legal;
    logic accept;
    logic in_var;
    logic in_mem;
    logic [7:0] in_count;
    logic [7:0] in_base;
    logic [7:0] ea_clk;
    sru_pkg::sru_op_t in_op;

    // Sequencer state
    sru_pkg::sru_state_t state;
    sru_pkg::sru_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] bits;
    logic [7:0] next_bits;
    logic single;
    logic next_single;
    logic step_en;
    logic finish;

    // Operand state
    logic [15:0] data;
    logic [15:0] next_data;
    logic carry;
    logic next_carry;
    logic wide;
    logic next_wide;
    sru_pkg::sru_op_t op;
    sru_pkg::sru_op_t next_op;
    logic mem;
    logic next_mem;

    // Output state
    logic next_busy;
    logic next_done;
    logic next_illegal;
    logic [15:0] next_result;
    logic next_res_carry;
    logic next_mem_operand;

    assign sif.data = data;
    assign sif.carry = carry;
    assign sif.wide = wide;
    assign sif.op = op;

    always_comb begin
        group_ok = i_opcode[7:2] == `SRU_OPC_GROUP;
        legal = group_ok;
        in_op = sru_pkg::LOGICAL_RIGHT_SHIFT;
        unique case (i_modrm[5:3])
            `SRU_SUB_ROTATE_LEFT: in_op = sru_pkg::ROTATE_LEFT_OP; // RL3
            `SRU_SUB_ROTATE_RIGHT: in_op = sru_pkg::ROTATE_RIGHT_OP; // RL4
            `SRU_SUB_ROTATE_CARRY_RIGHT: begin
                in_op = sru_pkg::ROTATE_CARRY_RIGHT_OP; // RL5
            end
            `SRU_SUB_LOGICAL_RIGHT_SHIFT: begin
                in_op = sru_pkg::LOGICAL_RIGHT_SHIFT; // RL1
            end
            `SRU_SUB_ARITHMETIC_RIGHT_SHIFT: begin
                in_op = sru_pkg::ARITHMETIC_RIGHT_SHIFT; // RL2
            end
            default: legal = 1'b0;
        endcase
        accept = i_start && (state == sru_pkg::ST_IDLE) && legal;
        in_var = i_opcode[`SRU_V_BIT];
        in_mem = i_modrm[7:6] != `SRU_MOD_REG;
        in_count = in_var ? i_count[7:0] : 8'h01; // RL10
        ea_clk = 8'(i_ea_time);
        if (in_var && in_mem) begin
            in_base = `SRU_CLK_VAR_MEM + ea_clk; // RL9
        end else if (in_var) begin
            in_base = `SRU_CLK_VAR_REG; // RL8
        end else if (in_mem) begin
            in_base = `SRU_CLK_SINGLE_MEM + ea_clk; // RL7
        end else begin
            in_base = `SRU_CLK_SINGLE_REG; // RL6
        end
    end

    // Sequencer: base cost, then a four-clock slot per counted bit of the variable form
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bits = bits;
        next_single = single;
        step_en = 1'b0;
        finish = 1'b0;
        unique case (state)
            sru_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = sru_pkg::ST_BASE;
                    next_cnt = in_base - 8'h01;
                    next_bits = in_var ? in_count : 8'h00;
                    next_single = !in_var;
                end
            end
            sru_pkg::ST_BASE: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else if (single) begin
                    step_en = 1'b1; // RL6 RL7
                    finish = 1'b1;
                end else if (bits == 8'h00) begin
                    finish = 1'b1; // RL8 RL9
                end else begin
                    next_state = sru_pkg::ST_BITS;
                    next_cnt = `SRU_CLK_PER_BIT - 8'h01; // RL8 RL9
                end
            end
            sru_pkg::ST_BITS: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else begin
                    step_en = 1'b1;
                    next_bits = bits - 8'h01;
                    if (bits == 8'h01) begin
                        finish = 1'b1;
                    end else begin
                        next_cnt = `SRU_CLK_PER_BIT - 8'h01; // RL8 RL9
                    end
                end
            end
        endcase
        if (finish) begin
            next_state = sru_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= sru_pkg::ST_IDLE;
            cnt <= 8'h00;
            bits <= 8'h00;
            single <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bits <= next_bits;
            single <= next_single;
        end
    end

    // Operand held while the instruction runs
    always_comb begin
        next_data = data;
        next_carry = carry;
        next_wide = wide;
        next_op = op;
        next_mem = mem;
        if (accept) begin
            next_data = i_operand;
            next_carry = i_carry;
            next_wide = i_opcode[`SRU_W_BIT]; // RL11
            next_op = in_op;
            next_mem = in_mem;
        end else if (step_en) begin
            next_data = sif.next_data;
            next_carry = sif.next_carry;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data <= 16'h0000;
            carry <= 1'b0;
            wide <= 1'b0;
            op <= sru_pkg::ROTATE_LEFT_OP;
            mem <= 1'b0;
        end else begin
            data <= next_data;
            carry <= next_carry;
            wide <= next_wide;
            op <= next_op;
            mem <= next_mem;
        end
    end

    // Completion outputs
    always_comb begin
        next_busy = next_state != sru_pkg::ST_IDLE;
        next_done = finish;
        next_illegal = i_start && (state == sru_pkg::ST_IDLE) && !legal;
        next_result = o_result;
        next_res_carry = o_carry;
        next_mem_operand = o_mem_operand;
        if (finish) begin
            next_result = next_data;
            next_res_carry = next_carry;
            next_mem_operand = mem;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_illegal <= 1'b0;
            o_result <= 16'h0000;
            o_carry <= 1'b0;
            o_mem_operand <= 1'b0;
        end else begin
            o_busy <= next_busy;
            o_done <= next_done;
            o_illegal <= next_illegal;
            o_result <= next_result;
            o_carry <= next_res_carry;
            o_mem_operand <= next_mem_operand;
        end
    end
endmodule

// ==== tb/sru_assertions.sv ====
// Concurrent checks of the shift and rotate unit, bound into its top
`timescale 1ns/1ps
module sru_assertions #(
    parameter int EA_W = 6
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_modrm,
    input wire logic [15:0] i_operand,
    input wire logic [15:0] i_count,
    input wire logic i_carry,
    input wire logic [EA_W-1:0] i_ea_time,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_illegal,
    input wire logic [15:0] o_result,
    input wire logic o_carry,
    input wire logic o_mem_operand
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic legal, acc, mem, run, v_l, mem_l, wide_l;
    logic [7:0] hi_l;
    int cnt;
    int exp_t;
    assign legal = i_opcode[7:2] == 6'h34
        && (i_modrm[5:3] == 3'h0 || i_modrm[3]);
    assign mem = i_modrm[7:6] != 2'h3;
    assign acc = i_start && !o_busy && legal;
    // Cycles since the accepted request and the cost it should take
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run <= 1'b0;
        end else if (acc) begin
            run <= 1'b1;
            cnt <= 0;
            v_l <= i_opcode[1];
            mem_l <= mem;
            wide_l <= i_opcode[0];
            hi_l <= i_operand[15:8];
            exp_t <= i_opcode[1] ? 8 + 4 * i_count[7:0]
                + (mem ? 12 + i_ea_time : 0) : (mem ? 15 + i_ea_time : 2);
        end else if (o_done) begin
            run <= 1'b0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    sequence s_quick;
        !o_done ##1 !o_done ##1 o_done;
    endsequence
    sequence s_refuse;
        o_illegal && !o_busy && !o_done && $stable(o_result);
    endsequence
    a_single_reg: assert property (acc && !i_opcode[1] && !mem |=> s_quick)
        else $error("single register op off time");
    a_refused_code: assert property (i_start && !o_busy && !legal |=> s_refuse)
        else $error("bad code not refused");
    a_single_mem: assert property (run && !v_l && mem_l |-> o_done == (cnt == exp_t))
        else $error("single memory op off time");
    a_var_reg: assert property (run && v_l && !mem_l |-> o_done == (cnt == exp_t))
        else $error("variable register op off time");
    a_var_mem: assert property (run && v_l && mem_l |-> o_done == (cnt == exp_t))
        else $error("variable memory op off time");
    a_busy_span: assert property (run && cnt > 0 |-> o_busy == (cnt < exp_t))
        else $error("busy span wrong");
    a_mem_flag: assert property (run && o_done |-> o_mem_operand == mem_l)
        else $error("memory flag wrong");
    a_byte_top: assert property (run && o_done && !wide_l |-> o_result[15:8] == hi_l)
        else $error("byte op touched upper byte");
endmodule
bind sru_top sru_assertions #(.EA_W(EA_W)) u_sru_assertions (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_opcode(i_opcode), .i_modrm(i_modrm), .i_operand(i_operand),
    .i_count(i_count), .i_carry(i_carry), .i_ea_time(i_ea_time),
    .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal),
    .o_result(o_result), .o_carry(o_carry), .o_mem_operand(o_mem_operand)
);

// ==== tb/shift_rotate_unit_tb.sv ====
// Randomised self-checking bench of the shift and rotate unit
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("CHECK FAILED %0t value mismatch", $time); end end
module shift_rotate_unit_tb;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_start = 1'b0;
    logic i_carry = 1'b0;
    logic [7:0] i_opcode = 8'h00;
    logic [7:0] i_modrm = 8'h00;
    logic [15:0] i_operand = 16'h0000;
    logic [15:0] i_count = 16'h0000;
    logic [5:0] i_ea_time = 6'h00;
    logic o_busy, o_done, o_illegal, o_carry, o_mem_operand;
    logic [15:0] o_result;
    logic [2:0] subs [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    int n_mismatch = 0;
    int num_checks = 0;
    int n_done = 0;
    int n0;
    int seed = 32'h71b4eab3;
    always #5 i_clk = ~i_clk;
    always @(negedge i_clk) if (o_done === 1'b1) n_done++;
    sru_top #(.EA_W(6)) u_sru_top (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_opcode(i_opcode), .i_modrm(i_modrm), .i_operand(i_operand),
        .i_count(i_count), .i_carry(i_carry), .i_ea_time(i_ea_time),
        .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal),
        .o_result(o_result), .o_carry(o_carry), .o_mem_operand(o_mem_operand)
    );
    // Returns carry over result after the whole count of one-bit steps
    function automatic logic [16:0] model(logic [2:0] s, logic w, logic v,
        logic [15:0] d, logic [7:0] n, logic c);
        logic [15:0] x;
        logic tp;
        int top;
        top = w ? 15 : 7;
        x = w ? d : {8'h00, d[7:0]};
        for (int k = 0; k < (v ? n : 1); k++) begin
            tp = x[top];
            case (s)
                3'h0: begin c = tp; x = {x[14:0], tp}; end
                3'h1: begin c = x[0]; x = x >> 1; x[top] = c; end
                3'h3: begin tp = x[0]; x = x >> 1; x[top] = c; c = tp; end
                3'h5: begin c = x[0]; x = x >> 1; end
                default: begin c = x[0]; x = x >> 1; x[top] = tp; end
            endcase
            if (!w) x[15:8] = 8'h00;
        end
        return {c, w ? x : {d[15:8], x[7:0]}};
    endfunction
    function automatic int lat(logic v, logic m, logic [7:0] n, logic [5:0] e);
        return v ? 8 + 4 * n + (m ? 12 + e : 0) : (m ? 15 + e : 2);
    endfunction
    task automatic run(logic [7:0] opc, logic [7:0] mrm, logic [15:0] d,
        logic [7:0] n, logic c, logic [5:0] e);
        int k;
        logic [16:0] ex;
        logic bad;
        bad = opc[7:2] != 6'h34 || !(mrm[5:3] == 3'h0 || mrm[3]);
        ex = model(mrm[5:3], opc[0], opc[1], d, n, c);
        @(posedge i_clk);
        i_start <= 1'b1;
        i_opcode <= opc;
        i_modrm <= mrm;
        i_operand <= d;
        i_count <= {8'($random(seed)), n};
        i_carry <= c;
        i_ea_time <= e;
        @(posedge i_clk);
        i_start <= 1'b0;
        k = 0;
        // The refusal pulse stands only in the cycle after the taking edge
        #1;
        while (o_done !== 1'b1 && o_illegal !== 1'b1 && k < 1200) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        if (bad) begin
            `CHK({o_illegal, o_busy}, 2'b10)
            `CHK(k, 0)
        end else begin
            `CHK(k, lat(opc[1], mrm[7:6] != 2'h3, n, e))
            `CHK({o_carry, o_result}, ex)
            `CHK(o_mem_operand, mrm[7:6] != 2'h3)
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // About fifty times the longest single run of 1103 clocks
    initial begin
        #600000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        foreach (subs[s])
            for (int m = 0; m < 4; m++)
                run({6'h34, 2'(m)}, {2'h3, subs[s], 3'h1}, 16'h80c1,
                    8'h02, subs[s][1], 6'h05);
        run(8'hd3, 8'hd8, 16'h8001, 8'h00, 1'b1, 6'h00);
        run(8'hd2, 8'h38, 16'h00ff, 8'hff, 1'b0, 6'h3f);
        for (int s = 2; s < 7; s += 2)
            run(8'hd1, {2'h3, 3'(s), 3'h0}, 16'h1234, 8'h01, 1'b0, 6'h00);
        run(8'hd4, 8'hc0, 16'h1234, 8'h01, 1'b0, 6'h00);
        repeat (30)
            run({6'h34, 2'($random(seed))}, {2'($random(seed)),
                subs[{$random(seed)} % 5], 3'($random(seed))},
                16'($random(seed)), 8'($random(seed)), 1'($random(seed)),
                6'($random(seed)));
        // Held request is taken again on the edge after each done
        @(posedge i_clk);
        n0 = n_done;
        i_start <= 1'b1;
        i_opcode <= 8'hd1;
        i_modrm <= 8'hc8;
        repeat (12) @(posedge i_clk);
        i_start <= 1'b0;
        repeat (4) @(posedge i_clk);
        `CHK(n_done - n0, 4)
        conclude();
    end
endmodule
